// *** hdl/ssp_defs.svh ***
// Constants of the serial programming port: opcodes, fill values, wait delays.
// Assumes inclusion by bare name from files compiled after it.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// First and second byte of the enable instruction
`define SSP_OP_ENABLE      8'hac
`define SSP_OP_ENABLE_KEY  8'h53
// Top three bits of the second byte of a chip erase
`define SSP_ERASE_KEY_TOP  3'b100
// Program memory read, low and high byte
`define SSP_OP_RD_PROG_LO  8'h20
`define SSP_OP_RD_PROG_HI  8'h28
// Page buffer load, low and high byte
`define SSP_OP_LD_PAGE_LO  8'h40
`define SSP_OP_LD_PAGE_HI  8'h48
// Page commit
`define SSP_OP_WR_PAGE     8'h4c
// Data memory read and write
`define SSP_OP_RD_EE       8'ha0
`define SSP_OP_WR_EE       8'hc0
// Erased content
`define SSP_ERASED_BYTE    8'hff
`define SSP_ERASED_WORD    16'hffff
// Bit position of the byte select in program memory opcodes
`define SSP_HI_SEL_BIT     3

// CPU clock period
`define SSP_CLK_PERIOD_NS  8
// Least wait delays, in ns as printed in ms
`define SSP_T_WD_FLASH_NS  4500000
`define SSP_T_WD_EEPROM_NS 9000000
`define SSP_T_WD_ERASE_NS  9000000
// Least times round up to whole cycles
`define SSP_FLASH_WAIT_CYC \
  ((`SSP_T_WD_FLASH_NS + `SSP_CLK_PERIOD_NS - 1) / `SSP_CLK_PERIOD_NS)
`define SSP_EEPROM_WAIT_CYC \
  ((`SSP_T_WD_EEPROM_NS + `SSP_CLK_PERIOD_NS - 1) / `SSP_CLK_PERIOD_NS)
`define SSP_ERASE_WAIT_CYC \
  ((`SSP_T_WD_ERASE_NS + `SSP_CLK_PERIOD_NS - 1) / `SSP_CLK_PERIOD_NS)

`endif

// *** hdl/ssp_pkg.sv ***
// Types shared by the serial programming port.
// Assumes nothing beyond a SystemVerilog compiler.
package ssp_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0]
  {
    SSP_IDLE   = 5'b0_0001, // Ready for a new operation
    SSP_ERASE  = 5'b0_0010, // Sweeping both arrays to erased
    SSP_COMMIT = 5'b0_0100, // Copying page buffer into flash
    SSP_EEPROG = 5'b0_1000, // Erase then write one data byte
    SSP_WAIT   = 5'b1_0000  // Self-timed delay runs out
  } ssp_state_e;

  // One serial byte
  typedef logic [7:0] ssp_byte_t;

endpackage

// *** hdl/ssp_link_if.sv ***
// Carrier between the serial shifter and the programming core.
// Assumes the core holds tx_byte steady from one received byte to the next.
`timescale 1ns/1ns
`default_nettype none

interface ssp_link_if;
  ssp_pkg::ssp_byte_t rx_byte;   // Last byte shifted in, link domain
  logic               rx_toggle; // Flips once per received byte
  ssp_pkg::ssp_byte_t tx_byte;   // Next byte to shift out, core domain

  // Link side
  modport link (output rx_byte, output rx_toggle, input tx_byte);
  // Core side
  modport core (input rx_byte, input rx_toggle, output tx_byte);
endinterface

`default_nettype wire

// *** hdl/ssp_shifter.sv ***
// Serial shifter clocked by the programmer's SCK.
// Assumes link_rst_n is low whenever the device is not in programming reset.
`timescale 1ns/1ns
`default_nettype none

module ssp_shifter
(
  input  wire logic sck,        // Serial clock from the programmer
  input  wire logic link_rst_n, // Async reset, realigns byte framing
  input  wire logic mosi,       // Serial data in
  output var  logic miso,       // Serial data out
  ssp_link_if.link  lnk         // Byte exchange with the core
);

  logic [2:0] bit_cnt; // Bits of the current byte taken
  logic [6:0] shreg;   // Bits taken so far, MSB first

  ////////////////////////////////////////////////////////////////////////////
  // Input shifting on the rising edge
  ////////////////////////////////////////////////////////////////////////////

  // Data is sampled on rising SCK, MSB first
  always_ff @(posedge sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt       <= 3'h0;
      shreg         <= 7'h00;
      lnk.rx_byte   <= 8'h00;
      lnk.rx_toggle <= 1'b0;
    end
    else
    begin
      shreg   <= {shreg[5:0], mosi};
      bit_cnt <= bit_cnt + 3'h1;          // Wraps every byte
      // Eighth bit completes the byte; toggle tells the core
      if (bit_cnt == 3'h7)
      begin
        lnk.rx_byte   <= {shreg, mosi};
        lnk.rx_toggle <= ~lnk.rx_toggle;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifting on the falling edge
  ////////////////////////////////////////////////////////////////////////////

  // Next bit goes out on falling SCK; the core has half a bit time
  // after a byte ends to put up the reply, so very short SCK phases lose it
  always_ff @(negedge sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      miso <= 1'b0;
    end
    else
    begin
      miso <= lnk.tx_byte[3'h7 - bit_cnt];
    end
  end

endmodule

`default_nettype wire

// *** hdl/ssp_prog_port.sv ***
// Serial in-system programming port: decodes four-byte instructions,
// loads and commits flash pages, writes and erases data memory.
// Assumes SCK and MOSI come straight from pins and SCK may stop between bytes.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.svh"

// Summary of operation
// - Programming only while reset pin held low
// - Refuse writes until enable instruction executed
// - Data memory write includes its own erase
// - Chip erase fills both arrays with FF
// - Sample MOSI on rising SCK
// - Shift MISO out on falling SCK
// - Echo enable key byte; ignore when unsynchronised
// - Load page buffer byte at word address
// - Write page commits buffer at page address
// - Data memory written bytewise, auto erased
// - Read returns stored content on MISO
// - Reset pin high ends programming mode
// - Busy flash page reads as FF
// - Enable instruction is AC 53 xx xx
// - Busy data memory location reads as FF
module ssp_prog_port
#(
  parameter int PAGE_WORDS     = 64,                   // Words per flash page
  parameter int PAGES          = 128,                  // Flash pages
  parameter int EE_BYTES       = 512,                  // Data memory bytes
  parameter int FLASH_WAIT_CYC = `SSP_FLASH_WAIT_CYC,  // Page write delay
  parameter int EE_WAIT_CYC    = `SSP_EEPROM_WAIT_CYC, // Data byte delay
  parameter int ERASE_WAIT_CYC = `SSP_ERASE_WAIT_CYC   // Chip erase delay
)
(
  input  wire logic clk,            // CPU clock
  input  wire logic rst_n,          // CPU reset, async, active low
  input  wire logic target_reset_n, // Reset pin from programmer
  input  wire logic sck,            // Serial clock pin
  input  wire logic mosi,           // Serial data in pin
  output var  logic miso,           // Serial data out pin
  output var  logic prog_enabled,   // Enable instruction accepted
  output var  logic busy            // Self-timed operation running
);

  localparam int PW  = $clog2(PAGE_WORDS);   // Word-in-page bits
  localparam int PGW = $clog2(PAGES);        // Page bits
  localparam int FW  = PW + PGW;             // Flash word address bits
  localparam int EW  = $clog2(EE_BYTES);     // Data memory address bits
  localparam int TW  = 21;                   // Delay counter width
  localparam int SW  = (FW > EW) ? FW : EW;  // Sweep counter width

  ////////////////////////////////////////////////////////////////////////////
  // Serial link in its own clock domain
  ////////////////////////////////////////////////////////////////////////////

  ssp_link_if lnk ();          // Byte exchange between domains
  logic       link_rst_n;      // Link held in reset outside programming

  // Pin high or CPU reset clears framing, the only way to realign it
  assign link_rst_n = rst_n & ~target_reset_n;

  ssp_shifter u_shifter
  (
    .sck        (sck),
    .link_rst_n (link_rst_n),
    .mosi       (mosi),
    .miso       (miso),
    .lnk        (lnk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the CPU clock
  ////////////////////////////////////////////////////////////////////////////

  logic pin_s1;    // Reset pin, first stage
  logic pin_s2;    // Reset pin, second stage
  logic tog_s1;    // Byte toggle, first stage
  logic tog_s2;    // Byte toggle, second stage
  logic tog_s3;    // Byte toggle, edge reference
  logic prog_req;  // Programming reset present
  logic rx_stb;    // One cycle per received byte

  // Two stages for the pin and for the byte toggle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end
    else
    begin
      pin_s1 <= target_reset_n;
      pin_s2 <= pin_s1;
      tog_s1 <= lnk.rx_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  assign prog_req = ~pin_s2;
  assign rx_stb   = tog_s2 ^ tog_s3;  // rx_byte is settled by now

  ////////////////////////////////////////////////////////////////////////////
  // Instruction assembly
  ////////////////////////////////////////////////////////////////////////////

  logic [1:0]         byte_idx;  // Byte position within instruction
  ssp_pkg::ssp_byte_t ib0;       // Opcode byte
  ssp_pkg::ssp_byte_t ib1;       // Second byte
  ssp_pkg::ssp_byte_t ib2;       // Third byte
  ssp_pkg::ssp_byte_t rxb;       // Byte just received
  logic               instr_end; // Fourth byte just arrived

  assign rxb       = lnk.rx_byte;
  assign instr_end = rx_stb && (byte_idx == 2'h3);

  // Count and store bytes; cleared when the pin goes high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_idx <= 2'h0;
      ib0      <= 8'h00;
      ib1      <= 8'h00;
      ib2      <= 8'h00;
    end
    else if (!prog_req)
    begin
      byte_idx <= 2'h0;
    end
    else if (rx_stb)
    begin
      byte_idx <= byte_idx + 2'h1; // Always four bytes
      unique case (byte_idx)
        2'h0:    ib0 <= rxb;
        2'h1:    ib1 <= rxb;
        2'h2:    ib2 <= rxb;
        2'h3:    ib0 <= ib0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memories and sequencer state
  ////////////////////////////////////////////////////////////////////////////

  logic [15:0]        flash [PAGES*PAGE_WORDS]; // Program memory words
  ssp_pkg::ssp_byte_t eemem [EE_BYTES];         // Data memory bytes
  logic [15:0]        pbuf  [PAGE_WORDS];       // Page buffer
  ssp_pkg::ssp_state_e state;                   // Sequencer state
  logic [PGW-1:0]     busy_page;                // Page under commit
  logic [EW-1:0]      busy_ee;                  // Data byte under write
  ssp_pkg::ssp_byte_t ee_data;                  // Data byte to write
  logic               ee_op;                    // Running operation is a data byte write
  logic [SW-1:0]      sweep;                    // Erase or copy index
  logic [TW-1:0]      timer;                    // Remaining delay

  // Flash byte read, masked while its page or the chip is busy
  function automatic ssp_pkg::ssp_byte_t rd_flash(input logic hi_sel,
                                                  input logic [FW-1:0] wa);
    logic [15:0] w;
    w = flash[wa];
    if ((state == ssp_pkg::SSP_ERASE) ||
        ((state != ssp_pkg::SSP_IDLE) && !ee_op &&
         (wa[FW-1:PW] == busy_page)))
    begin
      rd_flash = `SSP_ERASED_BYTE;
    end
    else
    begin
      rd_flash = hi_sel ? w[15:8] : w[7:0];
    end
  endfunction

  // Data memory read, masked while that byte or the chip is busy
  function automatic ssp_pkg::ssp_byte_t rd_ee(input logic [EW-1:0] ea);
    if ((state == ssp_pkg::SSP_ERASE) ||
        ((state != ssp_pkg::SSP_IDLE) && ee_op && (ea == busy_ee)))
    begin
      rd_ee = `SSP_ERASED_BYTE;
    end
    else
    begin
      rd_ee = eemem[ea];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reply byte
  ////////////////////////////////////////////////////////////////////////////

  // Each byte is echoed one byte later, so the enable key shows during
  // the third byte; a read puts its data up for the fourth byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lnk.tx_byte <= 8'h00;
    end
    else if (rx_stb)
    begin
      if ((byte_idx == 2'h2) && prog_enabled &&
          ((ib0 == `SSP_OP_RD_PROG_LO) || (ib0 == `SSP_OP_RD_PROG_HI)))
      begin
        lnk.tx_byte <= rd_flash(ib0[`SSP_HI_SEL_BIT],
                                {ib1[4:0], rxb});
      end
      else if ((byte_idx == 2'h2) && prog_enabled && (ib0 == `SSP_OP_RD_EE))
      begin
        lnk.tx_byte <= rd_ee({ib1[0], rxb});
      end
      else
      begin
        lnk.tx_byte <= rxb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming enable
  ////////////////////////////////////////////////////////////////////////////

  // Only a correct key makes the link trusted; a wrong one is ignored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_enabled <= 1'b0;
    end
    else if (!prog_req)
    begin
      prog_enabled <= 1'b0;
    end
    else if (instr_end && (ib0 == `SSP_OP_ENABLE) &&
             (ib1 == `SSP_OP_ENABLE_KEY))
    begin
      prog_enabled <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  ////////////////////////////////////////////////////////////////////////////

  logic go; // Accepted instruction, enabled and idle

  assign go = instr_end && prog_enabled && (state == ssp_pkg::SSP_IDLE);

  // Starts self-timed operations and runs their delay; an operation
  // under way finishes even if the pin is released meanwhile
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= ssp_pkg::SSP_IDLE;
      busy      <= 1'b0;
      sweep     <= '0;
      timer     <= '0;
      busy_page <= '0;
      busy_ee   <= '0;
      ee_data   <= 8'h00;
      ee_op     <= 1'b0;
    end
    else
    begin
      if (timer != '0)
      begin
        timer <= timer - TW'(1);
      end
      unique case (state)
        ssp_pkg::SSP_IDLE:
        begin
          sweep <= '0;
          if (go && (ib0 == `SSP_OP_ENABLE) &&
              (ib1[7:5] == `SSP_ERASE_KEY_TOP))
          begin
            state <= ssp_pkg::SSP_ERASE;
            busy  <= 1'b1;
            timer <= TW'(ERASE_WAIT_CYC);
            ee_op <= 1'b0;
          end
          else if (go && (ib0 == `SSP_OP_WR_PAGE))
          begin
            state     <= ssp_pkg::SSP_COMMIT;
            busy      <= 1'b1;
            busy_page <= PGW'({ib1[4:0], ib2[7:6]});
            timer     <= TW'(FLASH_WAIT_CYC);
            ee_op     <= 1'b0;                     // Stale data address must not mask
          end
          else if (go && (ib0 == `SSP_OP_WR_EE))
          begin
            state   <= ssp_pkg::SSP_EEPROG;
            busy    <= 1'b1;
            busy_ee <= EW'({ib1[0], ib2});
            ee_data <= rxb;
            timer   <= TW'(EE_WAIT_CYC);
            ee_op   <= 1'b1;               // Stale page must not mask
          end
        end
        ssp_pkg::SSP_ERASE:
        begin
          // Sweep runs over every flash word
          sweep <= sweep + SW'(1);
          if (sweep == SW'(PAGES*PAGE_WORDS - 1))
          begin
            state <= ssp_pkg::SSP_WAIT;
          end
        end
        ssp_pkg::SSP_COMMIT:
        begin
          sweep <= sweep + SW'(1);
          if (sweep == SW'(PAGE_WORDS - 1))
          begin
            state <= ssp_pkg::SSP_WAIT;
          end
        end
        ssp_pkg::SSP_EEPROG:
        begin
          // Cycle 0 erases, cycle 1 writes
          sweep <= sweep + SW'(1);
          if (sweep == SW'(1))
          begin
            state <= ssp_pkg::SSP_WAIT;
          end
        end
        ssp_pkg::SSP_WAIT:
        begin
          if (timer <= TW'(1))
          begin
            state <= ssp_pkg::SSP_IDLE;
            busy  <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory writes
  ////////////////////////////////////////////////////////////////////////////

  // Memories carry no reset; only the sequencer and loads change them
  always_ff @(posedge clk)
  begin
    if (go && ((ib0 == `SSP_OP_LD_PAGE_LO) || (ib0 == `SSP_OP_LD_PAGE_HI)))
    begin
      // Byte select comes from the opcode, word from the third byte
      if (ib0[`SSP_HI_SEL_BIT])
      begin
        pbuf[ib2[PW-1:0]][15:8] <= rxb;
      end
      else
      begin
        pbuf[ib2[PW-1:0]][7:0] <= rxb;
      end
    end
    if (state == ssp_pkg::SSP_ERASE)
    begin
      flash[sweep[FW-1:0]] <= `SSP_ERASED_WORD;
      if (sweep < SW'(EE_BYTES))
      begin
        eemem[sweep[EW-1:0]] <= `SSP_ERASED_BYTE;
      end
    end
    if (state == ssp_pkg::SSP_COMMIT)
    begin
      // Buffer is emptied as it is copied
      flash[{busy_page, sweep[PW-1:0]}] <= pbuf[sweep[PW-1:0]];
      pbuf[sweep[PW-1:0]]               <= `SSP_ERASED_WORD;
    end
    if (state == ssp_pkg::SSP_EEPROG)
    begin
      eemem[busy_ee] <= (sweep == '0) ? `SSP_ERASED_BYTE : ee_data;
    end
  end

endmodule

`default_nettype wire

// *** test/ssp_prog_port_properties.sv ***
// Pin-level checks for the serial programming port.
// Assumes binding to ssp_prog_port; rst_n is the CPU-domain reset.
`timescale 1ns/1ns
`default_nettype none

module ssp_prog_port_properties
#(
  parameter int FLASH_WAIT_CYC = 200, // Page write delay
  parameter int EE_WAIT_CYC    = 200, // Data byte delay
  parameter int ERASE_WAIT_CYC = 200  // Chip erase delay
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic target_reset_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic prog_enabled,
  input wire logic busy
);
  // Shortest and longest self-timed spans; one cycle slack for the start
  localparam int MIN_A = (EE_WAIT_CYC < FLASH_WAIT_CYC) ? EE_WAIT_CYC : FLASH_WAIT_CYC;
  localparam int MIN_WAIT = (MIN_A < ERASE_WAIT_CYC) ? MIN_A : ERASE_WAIT_CYC;
  localparam int MAX_WAIT = FLASH_WAIT_CYC + EE_WAIT_CYC + ERASE_WAIT_CYC + 16384;

  logic [31:0] busy_len; // Cycles busy has stood so far

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Busy span counter, cleared whenever busy drops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_len <= 32'h0000_0000;
    else if (busy)
      busy_len <= busy_len + 32'h0000_0001;
    else
      busy_len <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_miso_on_fall:
  assert property ($changed(miso) |-> !sck) else $error("miso moved while sck high");
  a_enable_in_session:
  assert property ($rose(prog_enabled) |-> !target_reset_n) else $error("enabled off session");
  a_session_end_clears:
  assert property (target_reset_n [*4] |-> !prog_enabled) else $error("enable outlived session");
  a_no_write_unenabled:
  assert property (!prog_enabled && !busy |=> !busy) else $error("busy without enable");
  a_enable_holds:
  assert property (prog_enabled && !target_reset_n |=> prog_enabled) else $error("enable lost");
  a_busy_min_span:
  assert property ($fell(busy) |-> busy_len >= MIN_WAIT - 1) else $error("busy span too short");
  a_busy_max_span:
  assert property (busy_len <= MAX_WAIT) else $error("busy span too long");
  a_miso_quiet_idle:
  assert property (target_reset_n |-> miso == 1'b0) else $error("miso active off session");
endmodule

bind ssp_prog_port ssp_prog_port_properties
#(
  .FLASH_WAIT_CYC(FLASH_WAIT_CYC),
  .EE_WAIT_CYC   (EE_WAIT_CYC),
  .ERASE_WAIT_CYC(ERASE_WAIT_CYC)
) u_props (.clk(clk), .rst_n(rst_n), .target_reset_n(target_reset_n), .sck(sck),
           .mosi(mosi), .miso(miso), .prog_enabled(prog_enabled), .busy(busy));

`default_nettype wire

// *** test/ssp_isp_programmer.sv ***
// Behavioural in-system programmer driving the serial link.
// Assumes the caller leaves enough time between instructions.
`timescale 1ns/1ns
`default_nettype none

module ssp_isp_programmer
(
  output var logic sck,
  output var logic mosi,
  input  wire logic miso
);
  logic [31:0] reply; // Bits seen on miso, MSB first
  event        got;   // One instruction finished

  // Serial clock low at power-up
  initial
  begin
    sck = 1'b0;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Whole four-byte frame, 125 ns period; phases far above 3 CPU cycles
  task automatic xfer(input logic [31:0] ins);
    for (int i = 31; i >= 0; i--)
    begin
      mosi = ins[i];
      #62 sck = 1'b1;
      reply[i] = miso;
      #63 sck = 1'b0;
    end
    mosi = ~mosi;        // No stale level between frames
    #62 -> got;
  endtask
endmodule

`default_nettype wire

// *** test/tb_ssp_prog_port.sv ***
// Self-checking bench for the serial programming port.
// Assumes the programmer model and the bound pin checker.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.svh"

module tb_ssp_prog_port;
  typedef struct { logic [31:0] mask; logic [31:0] value; } ssp_exp_s;

  logic       clk;
  logic       rst_n;
  logic       target_reset_n;
  logic       sck;
  logic       mosi;
  logic       miso;
  logic       prog_enabled;
  logic       busy;
  int         n_errors;
  int         n_tests;
  int         cycles = 0;  // Hang guard
  integer     seed;
  logic [7:0] d1;          // Data byte values
  logic [7:0] d2;
  logic [7:0] lo;
  logic [7:0] hi;
  ssp_exp_s   q[$];        // Expected replies, oldest first
  ssp_exp_s   e;

  // Long waits cut, yet busy still outlasts one later instruction so a read lands while busy
  ssp_prog_port #(.FLASH_WAIT_CYC(2000), .EE_WAIT_CYC(2000), .ERASE_WAIT_CYC(200)) dut
  (.clk(clk), .rst_n(rst_n), .target_reset_n(target_reset_n), .sck(sck), .mosi(mosi),
   .miso(miso), .prog_enabled(prog_enabled), .busy(busy));

  ssp_isp_programmer prog (.sck(sck), .mosi(mosi), .miso(miso));

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Note the reply, send the frame, leave the core time to decode
  task automatic ins(input logic [31:0] w, input logic [31:0] m, input logic [31:0] x);
    q.push_back('{m, x});
    prog.xfer(w);
    repeat (8) @(negedge clk);
  endtask

  task automatic enable();
    ins(32'hac53_0000, 32'h00ff_ff00, 32'h00ac_5300);
    check("enabled", 32'(prog_enabled), 32'h0000_0001);
  endtask

  // Bounded poll of the busy flag
  task automatic wait_idle();
    for (int n = 0; n < 20000 && busy !== 1'b0; n++)
      @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reply watcher: oldest note against each finished frame
  always @(prog.got)
  begin
    e = q.pop_front();
    check("reply", prog.reply & e.mask, e.value);
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hc14a;
    clk = 1'b0;
    rst_n = 1'b0;
    target_reset_n = 1'b1;
    n_errors = 0;
    n_tests = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    target_reset_n = 1'b0;
    repeat (4) @(negedge clk); // Power-up wait shortened for run time
    // Wrong key is echoed but opens nothing
    ins(32'hac54_0000, 32'h00ff_ff00, 32'h00ac_5400);
    check("enabled", 32'(prog_enabled), 32'h0000_0000);
    enable();
    // Chip erase then both arrays read erased
    ins(32'hac80_0000, 32'h00ff_ffff, 32'h00ac_8000);
    check("busy", 32'(busy), 32'h0000_0001);
    wait_idle();
    ins(32'ha001_a500, 32'h0000_00ff, 32'h0000_00ff);
    ins(32'h2000_c500, 32'h0000_00ff, 32'h0000_00ff);
    // Session end, then a write before enable must be dropped
    target_reset_n = 1'b1;
    repeat (6) @(negedge clk);
    check("enabled", 32'(prog_enabled), 32'h0000_0000);
    target_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    ins(32'hc001_a53c, 32'h00ff_ffff, 32'h00c0_01a5);
    check("busy", 32'(busy), 32'h0000_0000);
    enable();
    ins(32'ha001_a500, 32'h0000_00ff, 32'h0000_00ff);
    // Data byte write, poll while busy, then overwrite without erase
    d1 = 8'($random(seed));
    d2 = ~d1;
    ins({8'hc0, 16'h01a5, d1}, 32'h00ff_ffff, 32'h00c0_01a5);
    ins(32'ha001_a500, 32'h0000_00ff, 32'h0000_00ff);
    wait_idle();
    ins(32'ha001_a500, 32'h0000_00ff, {24'h00_0000, d1});
    ins({8'hc0, 16'h01a5, d2}, 32'h00ff_ffff, 32'h00c0_01a5);
    wait_idle();
    ins(32'ha001_a500, 32'h0000_00ff, {24'h00_0000, d2});
    // Page 3 word 5: low then high load, commit, poll, verify
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    ins({8'h40, 16'h0005, lo}, 32'h00ff_ffff, 32'h0040_0005);
    ins({8'h48, 16'h0005, hi}, 32'h00ff_ffff, 32'h0048_0005);
    ins(32'h4c00_c000, 32'h00ff_ffff, 32'h004c_00c0);
    check("busy", 32'(busy), 32'h0000_0001);
    ins(32'h2000_c500, 32'h0000_00ff, 32'h0000_00ff);
    wait_idle();
    ins(32'h2000_c500, 32'h0000_00ff, {24'h00_0000, lo});
    ins(32'h2800_c500, 32'h0000_00ff, {24'h00_0000, hi});
    target_reset_n = 1'b1;
    give_verdict();
  end
endmodule

`default_nettype wire
